// ===== cam_clock_compare.sv
// constants package and the half-rate channel clock comparator
package cam_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_ALARMS = 4;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_SUMMARY = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_INT_MASK = 8'h10;
  // alarm bit positions, shared by status, mask and interrupt mask
  localparam int ALM_PLL_UNLOCK = 0;
  localparam int ALM_LINK_NOT_DATA = 1;
  localparam int ALM_SYSREF_REALIGN = 2;
  localparam int ALM_CLOCK_UPSET = 3;
  // control register bit positions
  localparam int CTRL_LINK_ENABLE = 0;
  localparam int CTRL_PIN_ALARM_SEL = 1;
  localparam int CTRL_CHAN_A_PD = 2;
  localparam int CTRL_CHAN_B_PD = 3;
  localparam int CTRL_GLOBAL_PD = 4;
  localparam int CTRL_W = 5;
  // reset values
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [3:0] INT_MASK_RESET = 4'hF;
  localparam logic [4:0] CONTROL_RESET = 5'h00;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // half-rate divider: one enable every two cycles of the device clock; HALF_DIV_INIT is its reset value
  localparam logic HALF_DIV_INIT = 1'h0;
endpackage

`timescale 1ns/1ns
module cam_clock_compare #(
  parameter int PHASE_W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic half_en,
  input wire logic armed,
  input wire logic [PHASE_W-1:0] chan_a_phase,
  input wire logic [PHASE_W-1:0] chan_b_phase,
  output logic upset_pulse
);
  logic upset_reg;
  logic upset_next;

  // elaboration guard: a zero-width phase bus leaves nothing to compare
  if (PHASE_W < 1)
  begin : g_bad_phase_w
    $error("cam_clock_compare: PHASE_W must be at least 1");
  end

  // any disagreement in one half-rate slot while armed counts as an upset
  always_comb
  begin
    upset_next = half_en && armed && (chan_a_phase != chan_b_phase);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      upset_reg <= 1'h0;
    else
      upset_reg <= upset_next;
  end

  assign upset_pulse = upset_reg;
endmodule

// ===== cam_alarm_monitor.sv
// alarm monitor: sticky alarm status, masks, clock upset check, AXI4-Lite registers
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module cam_alarm_monitor #(
  parameter int PHASE_W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [cam_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cam_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // alarm sources
  input wire logic serializer_pll_locked,
  input wire logic link_in_data_state,
  input wire logic sysref_realign,
  input wire logic [PHASE_W-1:0] chan_a_clk_phase,
  input wire logic [PHASE_W-1:0] chan_b_clk_phase,
  input wire logic power_down_pin,
  input wire logic calibration_done,
  // outputs
  output logic calibration_status_pin,
  output logic alarm_irq,
  output logic link_reset_n,
  output logic serializer_powerdown,
  output logic serializer_clk_en,
  output logic channel_a_powerdown,
  output logic channel_b_powerdown
);
  localparam int NA = cam_pkg::NUM_ALARMS;

  // elaboration guard: the highest register offset needs five address bits
  if (cam_pkg::ADDR_W < 5)
  begin : g_bad_addr_w
    $error("cam_alarm_monitor: address too narrow for register map");
  end

  logic [NA-1:0] status_reg;
  logic [NA-1:0] status_next;
  logic [NA-1:0] mask_reg;
  logic [NA-1:0] mask_next;
  logic [NA-1:0] int_mask_reg;
  logic [NA-1:0] int_mask_next;
  logic [cam_pkg::CTRL_W-1:0] control_reg;
  logic [cam_pkg::CTRL_W-1:0] control_next;
  logic half_en_reg;
  logic half_en_next;
  logic global_pd_reg;
  logic global_pd_next;
  logic pin_reg;
  logic pin_next;
  logic [NA-1:0] events;
  logic [NA-1:0] w1c;
  logic upset_pulse;
  logic global_pd;
  logic pd_exit;
  logic armed;
  logic summary;

  // write channel state
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  logic [cam_pkg::ADDR_W-1:0] waddr_reg;
  logic [cam_pkg::ADDR_W-1:0] waddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic wstrb0_reg;
  logic wstrb0_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  // read channel state
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic commit;
  logic wr_ok;

  // half-rate enable from a divide-by-two of the device clock
  always_comb
  begin
    half_en_next = ~half_en_reg;
  end

  // global power-down from mode bit or pin; its falling edge marks the exit
  assign global_pd = control_reg[cam_pkg::CTRL_GLOBAL_PD] | power_down_pin;
  assign pd_exit = global_pd_reg & ~global_pd;
  // comparing is only meaningful with both channels running and the link up
  assign armed = control_reg[cam_pkg::CTRL_LINK_ENABLE]
               & ~control_reg[cam_pkg::CTRL_CHAN_A_PD]
               & ~control_reg[cam_pkg::CTRL_CHAN_B_PD]
               & ~global_pd;

  cam_clock_compare #(
    .PHASE_W(PHASE_W)
  ) u_compare (
    .aclk(aclk),
    .aresetn(aresetn),
    .half_en(half_en_reg),
    .armed(armed),
    .chan_a_phase(chan_a_clk_phase),
    .chan_b_phase(chan_b_clk_phase),
    .upset_pulse(upset_pulse)
  );

  // alarm conditions, one bit per alarm type
  always_comb
  begin
    events = '0;
    events[cam_pkg::ALM_PLL_UNLOCK] = ~serializer_pll_locked;
    events[cam_pkg::ALM_LINK_NOT_DATA] = ~link_in_data_state;
    events[cam_pkg::ALM_SYSREF_REALIGN] = sysref_realign;
    events[cam_pkg::ALM_CLOCK_UPSET] = upset_pulse | pd_exit;
  end

  // write decode: a write commits once address and data are both held
  assign commit = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_ok = (waddr_reg == cam_pkg::OFF_STATUS) || (waddr_reg == cam_pkg::OFF_MASK)
              || (waddr_reg == cam_pkg::OFF_SUMMARY) || (waddr_reg == cam_pkg::OFF_CONTROL)
              || (waddr_reg == cam_pkg::OFF_INT_MASK);
  assign w1c = (commit && wstrb0_reg && waddr_reg == cam_pkg::OFF_STATUS)
             ? wdata_reg[NA-1:0] : '0;

  // sticky status: a new event wins over a clear in the same cycle
  always_comb
  begin
    status_next = (status_reg & ~w1c) | events;
  end

  // configuration registers, written through byte lane 0 only
  always_comb
  begin
    mask_next = mask_reg;
    int_mask_next = int_mask_reg;
    control_next = control_reg;
    if (commit && wstrb0_reg)
    begin
      if (waddr_reg == cam_pkg::OFF_MASK)
        mask_next = wdata_reg[NA-1:0];
      else if (waddr_reg == cam_pkg::OFF_CONTROL)
        control_next = wdata_reg[cam_pkg::CTRL_W-1:0];
      else if (waddr_reg == cam_pkg::OFF_INT_MASK)
        int_mask_next = wdata_reg[NA-1:0];
    end
  end

  // summary and pin; the pin shows calibration state unless alarm output is chosen
  assign summary = |(status_reg & ~mask_reg);
  always_comb
  begin
    global_pd_next = global_pd;
    pin_next = control_reg[cam_pkg::CTRL_PIN_ALARM_SEL] ? summary : calibration_done;
  end

  // axi write channel
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next = 1'h1;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next = 1'h1;
      wdata_next = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
    end
    if (commit)
    begin
      aw_held_next = 1'h0;
      w_held_next = 1'h0;
      bvalid_next = 1'h1;
      bresp_next = wr_ok ? cam_pkg::RESP_OKAY : cam_pkg::RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'h0;
    end
  end

  // axi read channel; unmapped addresses read zero with slverr
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'h1;
      rdata_next = 32'h0000_0000;
      rresp_next = cam_pkg::RESP_OKAY;
      if (s_axi_araddr == cam_pkg::OFF_STATUS)
        rdata_next[NA-1:0] = status_reg;
      else if (s_axi_araddr == cam_pkg::OFF_MASK)
        rdata_next[NA-1:0] = mask_reg;
      else if (s_axi_araddr == cam_pkg::OFF_SUMMARY)
        rdata_next[0] = summary;
      else if (s_axi_araddr == cam_pkg::OFF_CONTROL)
        rdata_next[cam_pkg::CTRL_W-1:0] = control_reg;
      else if (s_axi_araddr == cam_pkg::OFF_INT_MASK)
        rdata_next[NA-1:0] = int_mask_reg;
      else
        rresp_next = cam_pkg::RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_reg <= '0;
      mask_reg <= cam_pkg::MASK_RESET;
      int_mask_reg <= cam_pkg::INT_MASK_RESET;
      control_reg <= cam_pkg::CONTROL_RESET;
      half_en_reg <= cam_pkg::HALF_DIV_INIT;
      global_pd_reg <= 1'h0;
      pin_reg <= 1'h0;
      aw_held_reg <= 1'h0;
      w_held_reg <= 1'h0;
      waddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'h0;
      bvalid_reg <= 1'h0;
      bresp_reg <= cam_pkg::RESP_OKAY;
      rvalid_reg <= 1'h0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cam_pkg::RESP_OKAY;
    end
    else
    begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      int_mask_reg <= int_mask_next;
      control_reg <= control_next;
      half_en_reg <= half_en_next;
      global_pd_reg <= global_pd_next;
      pin_reg <= pin_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // one transfer per channel at a time keeps the slave free of queues
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign calibration_status_pin = pin_reg;
  assign alarm_irq = |(status_reg & ~int_mask_reg);
  // link held in reset, serializers off and clocks gated while disabled
  assign link_reset_n = control_reg[cam_pkg::CTRL_LINK_ENABLE];
  assign serializer_powerdown = ~control_reg[cam_pkg::CTRL_LINK_ENABLE];
  assign serializer_clk_en = control_reg[cam_pkg::CTRL_LINK_ENABLE];
  assign channel_a_powerdown = control_reg[cam_pkg::CTRL_CHAN_A_PD];
  assign channel_b_powerdown = control_reg[cam_pkg::CTRL_CHAN_B_PD];
endmodule

// ===== cam_alarm_monitor_props.sv
// bound checker on the alarm monitor ports
`timescale 1ns/1ns
module cam_alarm_monitor_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic alarm_irq,
  input wire logic calibration_status_pin,
  input wire logic link_reset_n,
  input wire logic serializer_powerdown,
  input wire logic serializer_clk_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // link controls all follow the one enable bit
  a_link_gated: assert property (serializer_clk_en == link_reset_n
    && serializer_powerdown == !link_reset_n) else $error("link controls disagree");
  // only a committed write can drop the interrupt, status is sticky
  a_irq_sticky: assert property ($fell(alarm_irq) |-> $rose(s_axi_bvalid))
    else $error("irq fell without a write");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == cam_pkg::RESP_OKAY
    || s_axi_bresp == cam_pkg::RESP_SLVERR) else $error("bad write response");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("upper read bits set");
  c_irq: cover property ($rose(alarm_irq));
  c_pin: cover property ($rose(calibration_status_pin));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == cam_pkg::RESP_SLVERR);
endmodule
bind cam_alarm_monitor cam_alarm_monitor_props props_u (.*);

// ===== cam_tb.sv
// self-checking bench for the alarm monitor over its register bus
`timescale 1ns/1ns
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, serializer_pll_locked, link_in_data_state, sysref_realign;
  logic power_down_pin, calibration_done, calibration_status_pin, alarm_irq;
  logic link_reset_n, serializer_powerdown, serializer_clk_en;
  logic channel_a_powerdown, channel_b_powerdown;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [0:0] chan_a_clk_phase, chan_b_clk_phase;
  int error_cnt = 0;
  int samples_checked = 0;
  localparam logic [1:0] OK = cam_pkg::RESP_OKAY;
  cam_alarm_monitor dut_u (.*);
  // free-running 100 MHz clock
  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  task final_report;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'h1)
    begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // wait out one edge so registered pins have settled; the caller compares afterwards,
  // since a task argument would be sampled before the wait
  task settle;
    @(posedge aclk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (n < 50 && !(s_axi_bvalid && s_axi_bready))
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    chk(n < 50 && s_axi_bresp === er, "write response");
    if (n >= 50)
      final_report;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (n < 50 && !(s_axi_rvalid && s_axi_rready))
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    chk(n < 50 && s_axi_rdata === d && s_axi_rresp === er, "read data");
    if (n >= 50)
      final_report;
  endtask
  // one-cycle alarm event on a chosen source
  task pulse(input int i);
    @(posedge aclk);
    case (i)
      0: serializer_pll_locked <= 1'h0;
      1: link_in_data_state <= 1'h0;
      2: sysref_realign <= 1'h1;
      default: power_down_pin <= 1'h1;
    endcase
    @(posedge aclk);
    serializer_pll_locked <= 1'h1;
    link_in_data_state <= 1'h1;
    sysref_realign <= 1'h0;
    power_down_pin <= 1'h0;
  endtask
  // main sequence; wstrb and chan_a_clk_phase are the only tied inputs
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {sysref_realign, power_down_pin, calibration_done, aresetn} = 4'h0;
    {serializer_pll_locked, link_in_data_state} = 2'h3;
    {chan_a_clk_phase, chan_b_clk_phase} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    settle;
    chk(link_reset_n === 1'h0 && serializer_powerdown === 1'h1, "reset link");
    rd(cam_pkg::OFF_STATUS, 32'h0, OK);
    rd(cam_pkg::OFF_MASK, 32'h0, OK);
    rd(cam_pkg::OFF_INT_MASK, 32'hF, OK);
    rd(cam_pkg::OFF_CONTROL, 32'h0, OK);
    for (int i = 0; i < 3; i++)
    begin
      pulse(i);
      rd(cam_pkg::OFF_STATUS, 32'h1 << i, OK);
      wr(cam_pkg::OFF_STATUS, 32'h0, OK);
      rd(cam_pkg::OFF_STATUS, 32'h1 << i, OK);
      wr(cam_pkg::OFF_STATUS, 32'h1 << i, OK);
      rd(cam_pkg::OFF_STATUS, 32'h0, OK);
    end
    wr(cam_pkg::OFF_MASK, 32'h1, OK);
    wr(cam_pkg::OFF_INT_MASK, 32'h0, OK);
    wr(cam_pkg::OFF_CONTROL, 32'h2, OK);
    pulse(0);
    rd(cam_pkg::OFF_SUMMARY, 32'h0, OK);
    rd(cam_pkg::OFF_STATUS, 32'h1, OK);
    settle;
    chk(calibration_status_pin === 1'h0 && alarm_irq === 1'h1, "masked");
    wr(cam_pkg::OFF_MASK, 32'h0, OK);
    rd(cam_pkg::OFF_SUMMARY, 32'h1, OK);
    settle;
    chk(calibration_status_pin === 1'h1, "alarm pin");
    wr(cam_pkg::OFF_INT_MASK, 32'h1, OK);
    settle;
    chk(alarm_irq === 1'h0, "irq masked");
    wr(cam_pkg::OFF_STATUS, 32'h1, OK);
    calibration_done <= 1'h1;
    settle;
    chk(calibration_status_pin === 1'h0, "pin cleared");
    wr(cam_pkg::OFF_CONTROL, 32'h1, OK);
    settle;
    chk(calibration_status_pin === 1'h1 && serializer_clk_en === 1'h1, "cal pin");
    chk(link_reset_n === 1'h1 && serializer_powerdown === 1'h0, "link up");
    // link was off, both channels powered, link now on: clear the flag before watching it
    wr(cam_pkg::OFF_STATUS, 32'h8, OK);
    rd(cam_pkg::OFF_STATUS, 32'h0, OK);
    // two mismatch cycles always cover one half-rate compare
    @(posedge aclk);
    chan_b_clk_phase <= 1'h1;
    repeat (2) @(posedge aclk);
    chan_b_clk_phase <= 1'h0;
    rd(cam_pkg::OFF_STATUS, 32'h8, OK);
    settle;
    chk(alarm_irq === 1'h1, "upset irq");
    wr(cam_pkg::OFF_STATUS, 32'h8, OK);
    rd(cam_pkg::OFF_STATUS, 32'h0, OK);
    wr(cam_pkg::OFF_CONTROL, 32'hD, OK);
    settle;
    chk(channel_a_powerdown === 1'h1 && channel_b_powerdown === 1'h1, "chan pd");
    wr(cam_pkg::OFF_CONTROL, 32'h10, OK);
    wr(cam_pkg::OFF_CONTROL, 32'h0, OK);
    rd(cam_pkg::OFF_STATUS, 32'h8, OK);
    wr(cam_pkg::OFF_STATUS, 32'h8, OK);
    pulse(3);
    rd(cam_pkg::OFF_STATUS, 32'h8, OK);
    wr(8'h20, 32'h1, cam_pkg::RESP_SLVERR);
    rd(8'h20, 32'h0, cam_pkg::RESP_SLVERR);
    // the upset flag is still set and unmasked, so the summary stays one after the write
    wr(cam_pkg::OFF_SUMMARY, 32'h0, OK);
    rd(cam_pkg::OFF_SUMMARY, 32'h1, OK);
    final_report;
  end
endmodule
